// File: design/cdr_clock_domain_reset_gen.sv
// Clock domain set with per-domain reset conditioning and clock export.
//
// Operation
// - Synchronized types add two domain-clocked reset registers.
// - Four reset types: polarity and synchronization.
// - Default base clock 20 ns, active-low reset.
// - Derived period is base times numerator over denominator.
// - Periods must lie strictly between 1 ps, 2.1 ms.
// - At most one base clock domain.
// - Each domain has a distinct reset name.
// - Reset name defaults to the asynchronous clear.
// - Exported clocks drive an output pin.
`timescale 1ns/1ps
module cdr_clock_domain_reset_gen #(
	parameter int NUM_DERIVED = 1,
	parameter longint BASE_PERIOD_PS = cdr_pkg::CDR_DEFAULT_PERIOD_PS,
	parameter logic [1:0] BASE_RST_KIND = cdr_pkg::CDR_RST_LOW,
	parameter logic BASE_EXPORT = 1'b0,
	parameter int DER_NUM [NUM_DERIVED] = '{default: 1},
	parameter int DER_DEN [NUM_DERIVED] = '{default: 1},
	parameter logic [1:0] DER_RST_KIND [NUM_DERIVED] = '{default: 2'h0},
	parameter logic DER_EXPORT [NUM_DERIVED] = '{default: 1'b0}
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [NUM_DERIVED-1:0] der_clk,
	input wire logic [NUM_DERIVED-1:0] der_rst_in,
	output logic base_rst_n,
	output logic [NUM_DERIVED-1:0] der_rst_n,
	output logic base_clk_out,
	output logic [NUM_DERIVED-1:0] der_clk_out,
	output logic config_error
);
	import cdr_pkg::*;

	// Clocks are not made here. The base clock and every derived clock
	// enter on pins, and the period parameters only describe them so that
	// the configuration can be checked; a mismatch between a parameter and
	// the clock really supplied goes unnoticed.

	// Each domain conditions its own reset pin into a low-true reset.
	// Plain kinds pass the pin through with only a polarity fix, while the
	// synchronized kinds add a two-stage chain on the domain's own clock.
	// Nothing here crosses between domains, so no domain ever waits on
	// another one during reset release.

	// A clock that is not exported still has its output port. It is held
	// low, and a wrapper that wants no pin simply leaves it unconnected.

	// Reset kind decoding, shared by the base domain and every derived one.
	function automatic logic kind_is_sync(input logic [1:0] kind);
		return kind[CDR_TYPE_SYNC_BIT];
	endfunction : kind_is_sync

	function automatic logic kind_is_high(input logic [1:0] kind);
		return kind[CDR_TYPE_POL_BIT];
	endfunction : kind_is_high

	// Maps a raw reset pin onto a low-true assert level for its kind.
	function automatic logic assert_level_n(input logic [1:0] kind,
		input logic raw);
		logic lvl_n;
		if (kind_is_high(kind)) begin
			lvl_n = ~raw;
		end else begin
			lvl_n = raw;
		end
		return lvl_n;
	endfunction : assert_level_n

	// Derived period in ps, rounded down. The ratio scales the period, not
	// the frequency, so a larger numerator gives a slower derived clock.
	function automatic longint period_of(input int num, input int den);
		longint scaled;
		scaled = BASE_PERIOD_PS * longint'(num);
		return scaled / longint'(den);
	endfunction : period_of

	// Both period limits are exclusive.
	function automatic logic period_ok(input longint p);
		logic above;
		logic below;
		above = p > CDR_MIN_PERIOD_PS;
		below = p < CDR_MAX_PERIOD_PS;
		return above && below;
	endfunction : period_ok

	function automatic logic ratio_ok(input int num, input int den);
		logic num_ok;
		logic den_ok;
		num_ok = num >= CDR_MIN_RATIO;
		den_ok = den >= CDR_MIN_RATIO;
		return num_ok && den_ok;
	endfunction : ratio_ok

	// The ratio is tested first, as a zero denominator would otherwise
	// stop elaboration with a division by zero instead of raising the flag.
	function automatic logic derived_bad(input int num, input int den);
		logic bad;
		if (!ratio_ok(num, den)) begin
			bad = 1'b1;
		end else begin
			bad = !period_ok(period_of(num, den));
		end
		return bad;
	endfunction : derived_bad

	// Configuration is fixed at elaboration, so the flag is a constant.
	// A wrapper can tie it to a build check rather than to a status
	// register; the block keeps running even when the flag is high, so
	// ignoring it gives a design whose clocks disagree with their setup.
	localparam logic BASE_BAD = !period_ok(BASE_PERIOD_PS);
	wire logic [NUM_DERIVED-1:0] der_bad;
	logic any_der_bad;
	assign any_der_bad = |der_bad;
	assign config_error = BASE_BAD | any_der_bad;

	// Base domain. It is the single clk port, so a second base clock cannot
	// be expressed and every further domain arrives as a derived clock.
	logic base_act_n;
	assign base_act_n = assert_level_n(BASE_RST_KIND, rst_n);

	generate
		if (kind_is_sync(BASE_RST_KIND)) begin : g_base_sync
			logic [CDR_SYNC_STAGES-1:0] sync_q;

			// Assertion clears the chain at once; release has to ripple a 1
			// through both stages, so a release that lands near a clk edge
			// can only disturb the first stage.
			always_ff @(posedge clk or negedge base_act_n) begin
				if (!base_act_n) begin
					sync_q <= '0;
				end else begin
					sync_q <= {sync_q[CDR_SYNC_STAGES-2:0], 1'b1};
				end
			end

			assign base_rst_n = sync_q[CDR_SYNC_STAGES-1];
		end else begin : g_base_async
			// No synchronizer: release timing is left to whoever drives
			// the pin, and a release near a clk edge is not protected.
			assign base_rst_n = base_act_n;
		end
	endgenerate

	generate
		if (BASE_EXPORT) begin : g_base_exp
			assign base_clk_out = clk;
		end else begin : g_base_noexp
			assign base_clk_out = 1'b0;
		end
	endgenerate

	// Derived domains, each on its own clock and its own reset pin. The
	// derived clocks need no phase relation to clk or to one another,
	// because every register below sees only its own domain's clock.
	genvar g;
	generate
		for (g = 0; g < NUM_DERIVED; g++) begin : g_der
			localparam logic DOM_BAD = derived_bad(DER_NUM[g], DER_DEN[g]);
			logic act_n;

			assign der_bad[g] = DOM_BAD;
			assign act_n = assert_level_n(DER_RST_KIND[g],
				der_rst_in[g]);

			if (kind_is_sync(DER_RST_KIND[g])) begin : g_sync
				logic [CDR_SYNC_STAGES-1:0] sync_q;

				// Same chain as the base domain, clocked by this domain only.
				always_ff @(posedge der_clk[g] or negedge act_n) begin
					if (!act_n) begin
						sync_q <= '0;
					end else begin
						sync_q <= {sync_q[CDR_SYNC_STAGES-2:0],
							1'b1};
					end
				end

				assign der_rst_n[g] = sync_q[CDR_SYNC_STAGES-1];
			end else begin : g_async
				// Plain kinds only fix the polarity of the pin.
				assign der_rst_n[g] = act_n;
			end

			if (DER_EXPORT[g]) begin : g_exp
				assign der_clk_out[g] = der_clk[g];
			end else begin : g_noexp
				assign der_clk_out[g] = 1'b0;
			end
		end
	endgenerate
endmodule : cdr_clock_domain_reset_gen

// File: design/cdr_pkg.sv
// Package with constants and types for the clock domain reset generator.
package cdr_pkg;
	// Reset type encodings for each domain.
	typedef enum logic [1:0] {
		CDR_RST_LOW = 2'b00,
		CDR_RST_HIGH = 2'b01,
		CDR_RST_SYNC_LOW = 2'b10,
		CDR_RST_SYNC_HIGH = 2'b11
	} cdr_rst_kind_type;
	localparam int CDR_SYNC_STAGES = 2;
	localparam int CDR_TYPE_SYNC_BIT = 1;
	localparam int CDR_TYPE_POL_BIT = 0;
	// Default base period in picoseconds and period limits.
	localparam longint CDR_DEFAULT_PERIOD_PS = 20000;
	localparam longint CDR_MIN_PERIOD_PS = 1;
	localparam longint CDR_MAX_PERIOD_PS = 2100000000;
	localparam int CDR_DEFAULT_SAMPLE_TIME = 1;
	localparam int CDR_MIN_RATIO = 1;
endpackage : cdr_pkg

// File: tb/cdr_chk_sva.sv
// Checker for reset conditioning and clock export.
`timescale 1ns/1ps
module cdr_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [0:0] der_clk,
	input wire logic [0:0] der_rst_in,
	input wire logic base_rst_n,
	input wire logic [0:0] der_rst_n,
	input wire logic base_clk_out,
	input wire logic [0:0] der_clk_out,
	input wire logic config_error
);
	a_base_rel_two: assert property (@(posedge clk)
		disable iff (!rst_n)
		$rose(rst_n) |-> !base_rst_n [*2] ##1 base_rst_n) else $error("rel");
	a_base_hit_now: assert property (@(posedge clk)
		!rst_n |-> !base_rst_n) else $error("hit");
	a_base_no_early: assert property (@(posedge clk)
		disable iff (!rst_n)
		$rose(base_rst_n) |-> $past(rst_n, 2)) else $error("early");
	a_der_rel_two: assert property (@(posedge der_clk[0])
		disable iff (der_rst_in[0])
		$fell(der_rst_in[0]) |-> !der_rst_n[0] [*2] ##1 der_rst_n[0])
		else $error("drel");
	a_der_hit_now: assert property (@(posedge der_clk[0])
		der_rst_in[0] |-> !der_rst_n[0]) else $error("dhit");
	a_base_clk_pin: assert property (@(negedge clk)
		base_clk_out == clk) else $error("bclk");
	a_der_clk_pin: assert property (@(negedge der_clk[0])
		der_clk_out[0] == der_clk[0]) else $error("dclk");
	a_cfg_legal: assert property (@(posedge clk) !config_error)
		else $error("cfg");
	cover property (@(posedge clk) $rose(base_rst_n));
	cover property (@(posedge clk) $fell(base_rst_n));
	cover property (@(posedge der_clk[0]) $rose(der_rst_n[0]));
endmodule : cdr_chk
bind cdr_clock_domain_reset_gen cdr_chk u_chk (
	.clk(clk),
	.rst_n(rst_n),
	.der_clk(der_clk),
	.der_rst_in(der_rst_in),
	.base_rst_n(base_rst_n),
	.der_rst_n(der_rst_n),
	.base_clk_out(base_clk_out),
	.der_clk_out(der_clk_out),
	.config_error(config_error)
);

// File: tb/tb_cdr_clock_domain_reset_gen.sv
// Bench for synchronized reset release in both domains.
`timescale 1ns/1ps
module tb_cdr_clock_domain_reset_gen;
	logic clk = 0, rst_n = 1, bo, bc, ce;
	logic [0:0] dc = 0, dr = 0, dro, dco;
	int miscompares = 0, n_checks = 0, seed = 86219;
	realtime qb[$], qd[$];
	always #2 clk = ~clk;
	always #3 dc = ~dc;
	// A 3/2 ratio on a 4 ns base gives the 6 ns derived clock.
	cdr_clock_domain_reset_gen #(.BASE_PERIOD_PS(4000), .BASE_RST_KIND(2'h2),
		.BASE_EXPORT(1'b1), .DER_NUM('{3}), .DER_DEN('{2}),
		.DER_RST_KIND('{2'h3}), .DER_EXPORT('{1'b1})) dut (.clk(clk),
		.rst_n(rst_n), .der_clk(dc), .der_rst_in(dr), .base_rst_n(bo),
		.der_rst_n(dro), .base_clk_out(bc), .der_clk_out(dco),
		.config_error(ce));
	task automatic chk(ref realtime q[$]);
		n_checks++;
		if (q.size() == 0 || q.pop_front() != $realtime) begin
			$display("BAD %0t release time", $time);
			miscompares++;
		end
	endtask : chk
	always @(posedge bo) chk(qb);
	always @(posedge dro[0]) chk(qd);
	task give_verdict();
		if (qb.size() + qd.size() != 0) begin
			$display("BAD %0t release never seen", $time);
			miscompares++;
		end
		$display("checks %0d bad %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	initial begin
		// Assert both resets between clock edges, so the async clears see
		// a real edge instead of the chains starting out unknown.
		#1;
		rst_n = 0;
		dr = 1;
		repeat (20) @(negedge clk);
		repeat (6) begin
			rst_n = 1;
			qb.push_back($realtime + 6);
			@(negedge dc) dr = 0;
			qd.push_back($realtime + 9);
			repeat (3 + {$random(seed)} % 4) @(negedge dc);
			dr = 1;
			@(negedge clk) rst_n = 0;
			repeat (1 + {$random(seed)} % 5) @(negedge clk);
			$display("release test done");
		end
		give_verdict();
	end
	initial begin
		#5000;
		miscompares++;
		give_verdict();
	end
endmodule : tb_cdr_clock_domain_reset_gen
